// File: core/aersc_pkg.sv
// Package with offsets, field positions, reset values and carrier types for the AER bank.
package aersc_pkg;
    localparam logic [11:0] AERSC_UNC_STATUS_OFF = 12'h104;
    localparam logic [11:0] AERSC_SEVERITY_OFF = 12'h10C;
    localparam logic [11:0] AERSC_CORR_STATUS_OFF = 12'h110;
    localparam logic [31:0] AERSC_SEVERITY_RESET = 32'h00062030;
    localparam logic [31:0] AERSC_SEVERITY_WMASK = 32'h001FF030;
    localparam logic [31:0] AERSC_UNC_STATUS_MASK = 32'h001FF010;
    localparam logic [31:0] AERSC_CORR_RESET = 32'h00000000;
    localparam int AERSC_UNSUP_REQ_SEV_BIT = 20;
    localparam int AERSC_UNEXP_CPL_SEV_BIT = 16;
    localparam int AERSC_FLOW_CTRL_SEV_BIT = 13;
    localparam int AERSC_SURPRISE_DOWN_SEV_BIT = 5;
    localparam int AERSC_LINK_PROTO_SEV_BIT = 4;
    localparam int AERSC_UNUSED_BIT = 0;
    localparam int AERSC_ADVISORY_BIT = 13;
    localparam int AERSC_REPLAY_TIMER_BIT = 12;
    localparam int AERSC_REPLAY_ROLL_BIT = 8;
    localparam int AERSC_BAD_DLLP_BIT = 7;
    localparam int AERSC_BAD_TLP_BIT = 6;
    localparam int AERSC_RX_ERR_BIT = 0;

    // One configuration space access from the host side.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } aersc_cfg_req_type;

    // Detector pulses, packet end markers and computed and received CRCs from the link and physical layers.
    typedef struct packed {
        logic rx_err;
        logic tlp_phy_err;
        logic tlp_end;
        logic tlp_edb;
        logic [31:0] tlp_crc_calc;
        logic [31:0] tlp_crc_rx;
        logic dllp_end;
        logic [15:0] dllp_crc_calc;
        logic [15:0] dllp_crc_rx;
        logic replay_timeout;
        logic replay_rollover;
        logic advisory_nonfatal;
    } aersc_link_evt_type;
endpackage : aersc_pkg

// File: core/aersc_regs.sv
// Severity and correctable status registers of the advanced error reporting bank.
`timescale 1ns/1ps

// Functional notes
// - Unsupported-request severity bit 20 is sticky, writable, resets to 0.
// - Flow control protocol severity bit 13 is sticky, writable, resets to 1.
// - Data link protocol severity bit 4 is sticky, writable, resets to 1.
// - Surprise-down severity bit 5 is sticky, writable, resets to 1.
// - Severity bit 0 and reserved ranges are read-only zero.
// - Correctable flags 13, 8, 0 are sticky, write-one-to-clear, reset 0.
// - Replay timer expiry sets sticky W1C flag bit 12.
// - DLLP CRC mismatch sets bad link packet flag bit 7.
// - Physical layer error during TLP reception sets bad TLP flag bit 6.
// - EDB-ended TLP whose CRC is not inverted computed CRC sets bad TLP.
// - Normally ended TLP with CRC mismatch sets bad TLP flag.
// - Severity bit applies to sticky W1C uncorrectable status at same position; status bit 5 is masked off, so surprise-down sets no flag or class.
module aersc_regs (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_sticky_reset,
    input wire aersc_pkg::aersc_cfg_req_type i_cfg,
    input wire aersc_pkg::aersc_link_evt_type i_link,
    input wire logic [31:0] i_unc_evt,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    output logic o_err_fatal,
    output logic o_err_nonfatal
);
    import aersc_pkg::*;

    logic [31:0] severity_q;
    logic [31:0] severity_d;
    logic [31:0] unc_status_q;
    logic [31:0] unc_status_d;
    logic [31:0] corr_status_q;
    logic [31:0] corr_status_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic fatal_q;
    logic fatal_d;
    logic nonfatal_q;
    logic nonfatal_d;
    logic [31:0] byte_mask;
    logic [31:0] wr_bits;
    logic [31:0] corr_set;
    logic [31:0] unc_set;
    logic bad_tlp;
    logic bad_dllp;

    // Byte enables widen to a bit mask so partial config writes touch only their lanes.
    assign byte_mask = {{8{i_cfg.be[3]}}, {8{i_cfg.be[2]}}, {8{i_cfg.be[1]}}, {8{i_cfg.be[0]}}};
    assign wr_bits = i_cfg.wdata & byte_mask;

    // Packet checks; an EDB-ended packet is nullified, so only a non-inverted CRC is bad.
    always_comb
    begin
        bad_dllp = i_link.dllp_end && (i_link.dllp_crc_calc != i_link.dllp_crc_rx);
        bad_tlp = i_link.tlp_phy_err;
        if (i_link.tlp_end && i_link.tlp_edb && (i_link.tlp_crc_rx != ~i_link.tlp_crc_calc))
        begin
            bad_tlp = 1'b1;
        end
        if (i_link.tlp_end && !i_link.tlp_edb && (i_link.tlp_crc_rx != i_link.tlp_crc_calc))
        begin
            bad_tlp = 1'b1;
        end
    end

    // Correctable status: a detector pulse in the clearing cycle wins over the clear.
    always_comb
    begin
        corr_set = 32'h00000000;
        corr_set[AERSC_ADVISORY_BIT] = i_link.advisory_nonfatal;
        corr_set[AERSC_REPLAY_TIMER_BIT] = i_link.replay_timeout;
        corr_set[AERSC_REPLAY_ROLL_BIT] = i_link.replay_rollover;
        corr_set[AERSC_BAD_DLLP_BIT] = bad_dllp;
        corr_set[AERSC_BAD_TLP_BIT] = bad_tlp;
        corr_set[AERSC_RX_ERR_BIT] = i_link.rx_err;
        corr_status_d = corr_status_q;
        if (i_cfg.wr && (i_cfg.addr == AERSC_CORR_STATUS_OFF))
        begin
            corr_status_d = corr_status_q & ~wr_bits;
        end
        corr_status_d = corr_status_d | corr_set;
    end

    // Severity: only the implemented bits take writes; bit 0 and reserved stay zero.
    always_comb
    begin
        severity_d = severity_q;
        if (i_cfg.wr && (i_cfg.addr == AERSC_SEVERITY_OFF))
        begin
            // Bit 16 stays writable; keeping it clear is left to software.
            severity_d = (severity_q & ~(byte_mask & AERSC_SEVERITY_WMASK))
                | (wr_bits & AERSC_SEVERITY_WMASK);
        end
    end

    // Uncorrectable status flags sit under the severity bits at the same positions.
    always_comb
    begin
        unc_set = i_unc_evt & AERSC_UNC_STATUS_MASK;
        unc_status_d = unc_status_q;
        if (i_cfg.wr && (i_cfg.addr == AERSC_UNC_STATUS_OFF))
        begin
            unc_status_d = unc_status_q & ~wr_bits;
        end
        unc_status_d = unc_status_d | unc_set;
    end

    // Sticky state: only the power-on reset clears it, so an ordinary reset keeps the log.
    always_ff @(posedge i_mclk)
    begin
        if (i_sticky_reset)
        begin
            severity_q <= AERSC_SEVERITY_RESET;
            unc_status_q <= 32'h00000000;
            corr_status_q <= AERSC_CORR_RESET;
        end
        else
        begin
            severity_q <= severity_d;
            unc_status_q <= unc_status_d;
            corr_status_q <= corr_status_d;
        end
    end

    // Read data and error class; an unmapped offset reads zero.
    always_comb
    begin
        rvalid_d = i_cfg.rd;
        rdata_d = rdata_q;
        if (i_cfg.rd)
        begin
            unique case (i_cfg.addr)
                AERSC_UNC_STATUS_OFF: rdata_d = unc_status_q;
                AERSC_SEVERITY_OFF: rdata_d = severity_q;
                AERSC_CORR_STATUS_OFF: rdata_d = corr_status_q;
                default: rdata_d = 32'h00000000;
            endcase
        end
        fatal_d = |(unc_set & severity_q);
        nonfatal_d = |(unc_set & ~severity_q);
    end

    // Non-sticky outputs follow either reset.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset || i_sticky_reset)
        begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
            fatal_q <= 1'b0;
            nonfatal_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            fatal_q <= fatal_d;
            nonfatal_q <= nonfatal_d;
        end
    end

    assign o_cfg_rdata = rdata_q;
    assign o_cfg_rvalid = rvalid_q;
    assign o_err_fatal = fatal_q;
    assign o_err_nonfatal = nonfatal_q;

    // Checks on the register behaviour.
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sticky_reset);

    AST_SEV_RESET: assert property ($past(i_sticky_reset) |-> severity_q == 32'h00062030)
        else $error("severity reset value wrong");
    AST_UR_WRITE: assert property (i_cfg.wr && i_cfg.addr == 12'h10C && i_cfg.be[2]
        |=> severity_q[20] == $past(i_cfg.wdata[20]))
        else $error("unsupported request severity not written");
    AST_SEV_BIT0: assert property (severity_q[0] == 1'b0 && severity_q[3:1] == 3'h0)
        else $error("reserved severity bits not zero");
    AST_SEV_RSVD_HIGH: assert property (severity_q[31:21] == 11'h000)
        else $error("high reserved severity bits not zero");
    AST_SEV_RSVD_MID: assert property (severity_q[11:6] == 6'h00)
        else $error("middle reserved severity bits not zero");
    AST_LINK_PROTOCOL_ERR_SEV_HOLD: assert property (!(i_cfg.wr && i_cfg.addr == 12'h10C)
        |=> $stable(severity_q[5:4]))
        else $error("link severity bits changed without write");
    AST_REPLAY_SET: assert property (i_link.replay_timeout |=> corr_status_q[12])
        else $error("replay timeout flag not set");
    AST_DLLP_SET: assert property (i_link.dllp_end
        && i_link.dllp_crc_calc != i_link.dllp_crc_rx |=> corr_status_q[7])
        else $error("bad link packet flag not set");
    AST_EDB_OK: assert property (i_link.tlp_end && i_link.tlp_edb && !i_link.tlp_phy_err
        && i_link.tlp_crc_rx == ~i_link.tlp_crc_calc && !corr_status_q[6] |=> !corr_status_q[6])
        else $error("nullified packet flagged bad");
    AST_TLP_CRC: assert property (i_link.tlp_end && !i_link.tlp_edb
        && i_link.tlp_crc_rx != i_link.tlp_crc_calc |=> corr_status_q[6])
        else $error("bad transaction packet flag not set");
    AST_PHY_TLP: assert property (i_link.tlp_phy_err |=> corr_status_q[6])
        else $error("physical error not flagged");
    AST_W1C: assert property (i_cfg.wr && i_cfg.addr == 12'h110 && i_cfg.be[0]
        && i_cfg.wdata[0] && !i_link.rx_err |=> !corr_status_q[0])
        else $error("receiver error flag not cleared");
    AST_CORR_RSVD: assert property (corr_status_q[31:14] == 18'h00000)
        else $error("correctable reserved bits set");
    // The class pulses also drop on an ordinary reset, so that reset masks these two checks.
    AST_FATAL: assert property (disable iff (i_reset || i_sticky_reset)
        i_unc_evt[4] && severity_q[4] |=> o_err_fatal)
        else $error("fatal class not reported");
    AST_NONFATAL: assert property (disable iff (i_reset || i_sticky_reset)
        i_unc_evt[20] && !severity_q[20] |=> o_err_nonfatal)
        else $error("nonfatal class not reported");
    AST_UNC_SET: assert property (i_unc_evt[20] |=> unc_status_q[20])
        else $error("uncorrectable status not set");

    COV_CORR_CLEAR: cover property (corr_status_q[0] ##1 !corr_status_q[0]);
    COV_NONFATAL: cover property (o_err_nonfatal);
    COV_FATAL: cover property (o_err_fatal);
    COV_SEV_WRITE: cover property (i_cfg.wr && i_cfg.addr == 12'h10C);
endmodule : aersc_regs

// File: tb/aersc_host_model.sv
// Host software model issuing configuration reads and writes to the AER bank.
`timescale 1ns/1ps
module aersc_host_model (
    input wire logic i_mclk,
    output aersc_pkg::aersc_cfg_req_type o_cfg,
    input wire logic [31:0] i_rdata,
    input wire logic i_rvalid
);
    import aersc_pkg::*;
    initial o_cfg = '0;
    // Posts one full word; the request stands across exactly one taking edge.
    task automatic cfg_wr(input logic [11:0] addr, input logic [31:0] data);
        @(negedge i_mclk);
        o_cfg.wr = 1'b1;
        o_cfg.addr = addr;
        o_cfg.be = 4'hF;
        // Software keeps the unexpected-completion severity at zero.
        o_cfg.wdata = (addr == AERSC_SEVERITY_OFF) ? (data & ~32'h00010000) : data;
        @(negedge i_mclk);
        o_cfg = '0;
    endtask : cfg_wr
    // The answer stands for one cycle only, so it is taken at the release edge.
    task automatic cfg_rd(input logic [11:0] addr, output logic [31:0] data, output logic ok);
        @(negedge i_mclk);
        o_cfg.rd = 1'b1;
        o_cfg.addr = addr;
        @(negedge i_mclk);
        o_cfg = '0;
        ok = i_rvalid;
        data = i_rdata;
    endtask : cfg_rd
endmodule : aersc_host_model

// File: tb/test_aersc_regs.sv
// Self-checking bench for the AER severity and correctable status registers.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_aersc_regs;
    import aersc_pkg::*;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic i_sticky_reset = 1'b1;
    aersc_cfg_req_type i_cfg;
    aersc_link_evt_type i_link = '0;
    logic [31:0] i_unc_evt = '0;
    logic [31:0] o_cfg_rdata;
    logic o_cfg_rvalid;
    logic o_err_fatal;
    logic o_err_nonfatal;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic ok;
    aersc_regs dut_u (.i_mclk(i_mclk), .i_reset(i_reset), .i_sticky_reset(i_sticky_reset),
        .i_cfg(i_cfg), .i_link(i_link), .i_unc_evt(i_unc_evt), .o_cfg_rdata(o_cfg_rdata),
        .o_cfg_rvalid(o_cfg_rvalid), .o_err_fatal(o_err_fatal), .o_err_nonfatal(o_err_nonfatal));
    aersc_host_model host_u (.i_mclk(i_mclk), .o_cfg(i_cfg), .i_rdata(o_cfg_rdata),
        .i_rvalid(o_cfg_rvalid));
    // Clock and a hang guard far above the roughly 150 cycles the run needs.
    always #2 i_mclk = ~i_mclk;
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        host_u.cfg_rd(a, rd, ok);
        `CHK("rvalid", 1'b1, ok)
        `CHK(nm, e, rd)
    endtask : chk_rd
    // One reset pulse; an ordinary reset must leave sticky state alone.
    task automatic rst(input logic sticky);
        @(negedge i_mclk);
        i_reset = 1'b1;
        i_sticky_reset = sticky;
        @(negedge i_mclk);
        i_reset = 1'b0;
        i_sticky_reset = 1'b0;
    endtask : rst
    task automatic t_reset_values();
        chk_rd(AERSC_SEVERITY_OFF, 32'h00062030, "severity");
        chk_rd(AERSC_CORR_STATUS_OFF, 32'h00000000, "correctable");
        chk_rd(12'h200, 32'h00000000, "unmapped");
    endtask : t_reset_values
    task automatic t_severity_rw();
        host_u.cfg_wr(AERSC_SEVERITY_OFF, 32'hFFFFFFFF);
        chk_rd(AERSC_SEVERITY_OFF, 32'h001EF030, "sev ones");
        host_u.cfg_wr(AERSC_SEVERITY_OFF, 32'h00100000);
        rst(1'b0);
        chk_rd(AERSC_SEVERITY_OFF, 32'h00100000, "sev sticky");
        rst(1'b1);
        chk_rd(AERSC_SEVERITY_OFF, 32'h00062030, "sev por");
    endtask : t_severity_rw
    // Case k drives one detector input; good CRC cases must leave the flags clear.
    task automatic evt(input int k, input logic [31:0] e);
        @(negedge i_mclk);
        i_link.rx_err = (k == 0);
        i_link.replay_rollover = (k == 1);
        i_link.advisory_nonfatal = (k == 2);
        i_link.replay_timeout = (k == 3);
        i_link.dllp_end = (k == 4 || k == 5);
        i_link.dllp_crc_calc = 16'hBEEF;
        i_link.dllp_crc_rx = (k == 4) ? 16'hBEEE : 16'hBEEF;
        i_link.tlp_phy_err = (k == 6);
        i_link.tlp_end = (k >= 7);
        i_link.tlp_edb = (k == 7 || k == 8);
        i_link.tlp_crc_calc = 32'h1234ABCD;
        i_link.tlp_crc_rx = (k == 8) ? ~32'h1234ABCD : (k == 10) ? 32'h1234ABCD : 32'h1234ABCC;
        @(negedge i_mclk);
        i_link = '0;
        rst(1'b0);
        chk_rd(AERSC_CORR_STATUS_OFF, e, "corr flag");
        host_u.cfg_wr(AERSC_CORR_STATUS_OFF, 32'hFFFFFFFF);
        chk_rd(AERSC_CORR_STATUS_OFF, 32'h00000000, "corr cleared");
    endtask : evt
    task automatic t_corr_events();
        evt(0, 32'h00000001);
        evt(1, 32'h00000100);
        evt(2, 32'h00002000);
        evt(3, 32'h00001000);
        evt(4, 32'h00000080);
        evt(5, 32'h00000000);
        evt(6, 32'h00000040);
        evt(7, 32'h00000040);
        evt(8, 32'h00000000);
        evt(9, 32'h00000040);
        evt(10, 32'h00000000);
    endtask : t_corr_events
    task automatic unc(input int b, input logic fat);
        @(negedge i_mclk);
        i_unc_evt[b] = 1'b1;
        @(negedge i_mclk);
        i_unc_evt = '0;
        `CHK("fatal", fat, o_err_fatal)
        `CHK("nonfatal", ~fat, o_err_nonfatal)
    endtask : unc
    task automatic t_uncorrectable();
        unc(20, 1'b0);
        unc(4, 1'b1);
        chk_rd(AERSC_UNC_STATUS_OFF, 32'h00100010, "unc status");
        host_u.cfg_wr(AERSC_UNC_STATUS_OFF, 32'h00100000);
        chk_rd(AERSC_UNC_STATUS_OFF, 32'h00000010, "unc w1c");
        host_u.cfg_wr(AERSC_SEVERITY_OFF, 32'h00100000);
        unc(20, 1'b1);
        unc(4, 1'b0);
    endtask : t_uncorrectable
    // Main sequence: two reset cycles, then each scenario in turn.
    initial
    begin
        repeat (2) @(negedge i_mclk);
        i_reset = 1'b0;
        i_sticky_reset = 1'b0;
        t_reset_values();
        t_severity_rw();
        t_corr_events();
        t_uncorrectable();
        conclude();
    end
endmodule : test_aersc_regs
